// file: rtl/dsi_lvds_output_config.sv
// Our own choice: the strobed register port.
`timescale 1ns/1ps
module dsi_lvds_output_config
  import bridge_cfg_pkg::*;
(
  // system clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  // clock band checks
  output logic chanABandOk,
  output logic chanBBandOk,
  // link domain
  input wire logic linkClk,
  input wire pixel_t pixA,
  input wire pixel_t pixB,
  output lvds_chan_t outA,
  output lvds_chan_t outB,
  output link_mode_t linkMode
);

  // ----------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------
  typedef struct packed {
    cfg_t cfg;
    cfg_t snap;
    logic tog;
    logic ackMeta;
    logic ackMid;
    logic ackLate;
    logic [7:0] rdData;
    logic bandAOk;
    logic bandBOk;
  } sys_state_t;

  typedef struct packed {
    logic rstMeta;
    logic rstMid;
    logic rstLate;
    logic rst;
    logic togMeta;
    logic togMid;
    logic togLate;
    logic seen;
    cfg_t cfg;
    lvds_chan_t chanA;
    lvds_chan_t chanB;
    link_mode_t mode;
  } link_state_t;

  sys_state_t s;
  sys_state_t next_s;
  link_state_t l;
  link_state_t next_l;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // band codes outside 0x08..0x64 are reserved
  function automatic logic bandInRange(input logic [7:0] code);
    bandInRange = (code >= BAND_FIRST) && (code <= BAND_LAST);
  endfunction

  // polarity, lane enables and colour bit placement for one channel
  function automatic lvds_chan_t fmtChan(
    input pixel_t p,
    input logic en,
    input logic fourthOn,
    input logic lowBits,
    input out_cfg_t pol
  );
    lvds_chan_t c;
    c = '0;
    if (en)
    begin
      c.enable = 1'b1;
      c.laneOn = fourthOn ? LANES_ALL : LANES_BASE;
      c.de = p.de ^ pol.dataEnableActiveLow;
      c.hs = p.hs ^ pol.hsyncActiveLow;
      c.vs = p.vs ^ pol.vsyncActiveLow;
      if (lowBits)
      begin
        // LSBs leave on lane four, or vanish when it is off
        c.baseData = {p.r[7:2], p.g[7:2], p.b[7:2]};
        c.fourthLaneData = {p.r[1:0], p.g[1:0], p.b[1:0]};
      end
      else
      begin
        c.baseData = {p.r[5:0], p.g[5:0], p.b[5:0]};
        c.fourthLaneData = {p.r[7:6], p.g[7:6], p.b[7:6]};
      end
      // a dark fourth lane carries nothing
      if (!fourthOn)
      begin
        c.fourthLaneData = '0;
      end
    end
    fmtChan = c;
  endfunction

  // ----------------------------------------------------------------
  // system domain: registers and config hand-off
  // ----------------------------------------------------------------
  // the snapshot only moves after the link side has acknowledged
  // the previous one, so the link can sample it at leisure
  always_comb
  begin
    next_s = s;
    next_s.ackMeta = l.seen;
    next_s.ackMid = s.ackMeta;
    next_s.ackLate = s.ackMid;
    if (regWr)
    begin
      case (regAddr)
        ADDR_RX_ARRANGE:
          next_s.cfg.rxArrange =
            rx_arrange_t'(regWrData[ARRANGE_LSB +: 2]);
        ADDR_BAND_A: next_s.cfg.chanARxClockBand = regWrData;
        ADDR_BAND_B: next_s.cfg.chanBRxClockBand = regWrData;
        ADDR_OUT_CFG: next_s.cfg.outCfg = out_cfg_t'(regWrData);
        default: next_s.cfg = s.cfg;
      endcase
    end
    // reads have no side effects; unmapped addresses read zero
    next_s.rdData = READ_IDLE;
    if (regRd)
    begin
      case (regAddr)
        ADDR_RX_ARRANGE:
        begin
          next_s.rdData[ARRANGE_LSB +: 2] = s.cfg.rxArrange;
        end
        ADDR_BAND_A: next_s.rdData = s.cfg.chanARxClockBand;
        ADDR_BAND_B: next_s.rdData = s.cfg.chanBRxClockBand;
        ADDR_OUT_CFG: next_s.rdData = s.cfg.outCfg;
        default: next_s.rdData = READ_IDLE;
      endcase
    end
    next_s.bandAOk = bandInRange(next_s.cfg.chanARxClockBand);
    next_s.bandBOk = bandInRange(next_s.cfg.chanBRxClockBand);
    if ((s.ackMid == s.ackLate) && (s.ackLate == s.tog)
        && (s.cfg != s.snap))
    begin
      next_s.snap = s.cfg;
      next_s.tog = ~s.tog;
    end
  end

  // synchronous reset to the documented defaults
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s <= '{cfg: CFG_RESET, snap: CFG_RESET, rdData: READ_IDLE,
             default: 1'b0};
    end
    else
    begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // link domain: config capture and output channels
  // ----------------------------------------------------------------
  // reset reaches the link side through its own synchroniser, so
  // the link clock must run while sys_rst is high
  always_comb
  begin
    next_l = l;
    next_l.rstMeta = sys_rst;
    next_l.rstMid = l.rstMeta;
    next_l.rstLate = l.rstMid;
    if (l.rstMid == l.rstLate)
    begin
      next_l.rst = l.rstLate;
    end
    next_l.togMeta = s.tog;
    next_l.togMid = l.togMeta;
    next_l.togLate = l.togMid;
    if ((l.togMid == l.togLate) && (l.togLate != l.seen))
    begin
      next_l.cfg = s.snap;
      next_l.seen = l.togLate;
    end
    // arrangement decode; unless singleLink is set, the reserved receiver setting shuts the outputs
    if (l.cfg.outCfg.singleLink)
    begin
      next_l.mode = LINK_SINGLE;
    end
    else
    begin
      case (l.cfg.rxArrange)
        RX_DUAL: next_l.mode = LINK_DUAL;
        RX_SINGLE: next_l.mode = LINK_DUAL;
        RX_TWO: next_l.mode = LINK_TWO;
        RX_RSVD: next_l.mode = LINK_OFF;
        default: next_l.mode = LINK_OFF;
      endcase
    end
    next_l.chanA = fmtChan(pixA, next_l.mode != LINK_OFF,
      l.cfg.outCfg.chanAFourthLaneOn,
      l.cfg.outCfg.chanALowBitsOnFourthLane, l.cfg.outCfg);
    next_l.chanB = fmtChan(pixB,
      (next_l.mode == LINK_DUAL) || (next_l.mode == LINK_TWO),
      l.cfg.outCfg.chanBFourthLaneOn,
      l.cfg.outCfg.chanBLowBitsOnFourthLane, l.cfg.outCfg);
    if (l.rst)
    begin
      next_l.seen = 1'b0;
      next_l.cfg = CFG_RESET;
      next_l.chanA = '0;
      next_l.chanB = '0;
      next_l.mode = LINK_OFF;
    end
  end

  always_ff @(posedge linkClk)
  begin
    l <= next_l;
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ----------------------------------------------------------------
  assign regRdData = s.rdData;
  assign chanABandOk = s.bandAOk;
  assign chanBBandOk = s.bandBOk;
  assign outA = l.chanA;
  assign outB = l.chanB;
  assign linkMode = l.mode;

  // ----------------------------------------------------------------
  // checks, system domain
  // ----------------------------------------------------------------
  property p_band_a_low;
    @(posedge clk) disable iff (sys_rst)
    (regWr && regAddr == ADDR_BAND_A && regWrData == 8'h07)
      |=> !chanABandOk ##0 s.cfg.chanARxClockBand == 8'h07;
  endproperty
  a_band_a_low: assert property (p_band_a_low)
    else $error("band A code 0x07 not flagged reserved");

  property p_band_b_high;
    @(posedge clk) disable iff (sys_rst)
    (regWr && regAddr == ADDR_BAND_B && regWrData == 8'h65)
      |=> !chanBBandOk;
  endproperty
  a_band_b_high: assert property (p_band_b_high)
    else $error("band B code 0x65 not flagged reserved");

  property p_band_top;
    @(posedge clk) disable iff (sys_rst)
    (regWr && regAddr == ADDR_BAND_A
      && (regWrData == 8'h63 || regWrData == 8'h64))
      |=> chanABandOk;
  endproperty
  a_band_top: assert property (p_band_top)
    else $error("top band code not accepted");

  property p_read_back;
    @(posedge clk) disable iff (sys_rst)
    (regWr && regAddr == ADDR_OUT_CFG)
      ##1 (regRd && regAddr == ADDR_OUT_CFG)
      |=> regRdData == $past(regWrData, 2);
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("read does not return last written value");

  // ----------------------------------------------------------------
  // checks, link domain
  // ----------------------------------------------------------------
  property p_de_pol;
    @(posedge linkClk) disable iff (l.rst)
    outA.enable |-> outA.de ==
      ($past(pixA.de) ^ $past(l.cfg.outCfg.dataEnableActiveLow));
  endproperty
  a_de_pol: assert property (p_de_pol)
    else $error("data-enable polarity wrong");

  property p_hs_pol;
    @(posedge linkClk) disable iff (l.rst)
    outB.enable |-> outB.hs ==
      ($past(pixB.hs) ^ $past(l.cfg.outCfg.hsyncActiveLow));
  endproperty
  a_hs_pol: assert property (p_hs_pol)
    else $error("hsync polarity wrong");

  property p_vs_pol;
    @(posedge linkClk) disable iff (l.rst)
    (outA.enable && $past(l.cfg.outCfg.vsyncActiveLow))
      |-> outA.vs == !$past(pixA.vs);
  endproperty
  a_vs_pol: assert property (p_vs_pol)
    else $error("vsync not active low");

  property p_dual;
    @(posedge linkClk) disable iff (l.rst)
    (!l.cfg.outCfg.singleLink
      && (l.cfg.rxArrange == RX_DUAL || l.cfg.rxArrange == RX_SINGLE))
      |=> linkMode == LINK_DUAL && outA.enable && outB.enable;
  endproperty
  a_dual: assert property (p_dual)
    else $error("dual link not selected");

  property p_two_single;
    @(posedge linkClk) disable iff (l.rst)
    (!l.cfg.outCfg.singleLink && l.cfg.rxArrange == RX_TWO)
      |=> linkMode == LINK_TWO && outA.enable && outB.enable;
  endproperty
  a_two_single: assert property (p_two_single)
    else $error("two single links not selected");

  property p_single;
    @(posedge linkClk) disable iff (l.rst)
    l.cfg.outCfg.singleLink
      |=> linkMode == LINK_SINGLE && outA.enable && !outB.enable;
  endproperty
  a_single: assert property (p_single)
    else $error("single link must enable A only");

  property p_a_lane_off;
    @(posedge linkClk) disable iff (l.rst)
    !l.cfg.outCfg.chanAFourthLaneOn
      |=> !outA.laneOn[3] && outA.fourthLaneData == 6'h00;
  endproperty
  a_a_lane_off: assert property (p_a_lane_off)
    else $error("channel A fourth lane active in 18 bpp");

  property p_b_lane_on;
    @(posedge linkClk) disable iff (l.rst)
    (l.cfg.outCfg.chanBFourthLaneOn && !l.cfg.outCfg.singleLink
      && l.cfg.rxArrange != RX_RSVD)
      |=> outB.laneOn == LANES_ALL;
  endproperty
  a_b_lane_on: assert property (p_b_lane_on)
    else $error("channel B fourth lane not enabled");

  property p_a_msb;
    @(posedge linkClk) disable iff (l.rst)
    (!l.cfg.outCfg.chanALowBitsOnFourthLane
      && l.cfg.outCfg.chanAFourthLaneOn && l.cfg.outCfg.singleLink)
      |=> outA.fourthLaneData ==
        {$past(pixA.r[7:6]), $past(pixA.g[7:6]), $past(pixA.b[7:6])};
  endproperty
  a_a_msb: assert property (p_a_msb)
    else $error("channel A lane four lacks MSBs");

  property p_b_lsb;
    @(posedge linkClk) disable iff (l.rst)
    (l.cfg.outCfg.chanBLowBitsOnFourthLane
      && l.cfg.outCfg.chanBFourthLaneOn && !l.cfg.outCfg.singleLink
      && l.cfg.rxArrange != RX_RSVD)
      |=> outB.fourthLaneData ==
        {$past(pixB.r[1:0]), $past(pixB.g[1:0]), $past(pixB.b[1:0])};
  endproperty
  a_b_lsb: assert property (p_b_lsb)
    else $error("channel B lane four lacks LSBs");

  property p_drop_lsb;
    @(posedge linkClk) disable iff (l.rst)
    (l.cfg.outCfg.chanALowBitsOnFourthLane
      && !l.cfg.outCfg.chanAFourthLaneOn && l.cfg.outCfg.singleLink)
      |=> outA.baseData ==
        {$past(pixA.r[7:2]), $past(pixA.g[7:2]), $past(pixA.b[7:2])}
        && outA.laneOn == LANES_BASE;
  endproperty
  a_drop_lsb: assert property (p_drop_lsb)
    else $error("24 to 18 bpp conversion wrong");

  property p_rsvd;
    @(posedge linkClk) disable iff (l.rst)
    (!l.cfg.outCfg.singleLink && l.cfg.rxArrange == RX_RSVD)
      |=> linkMode == LINK_OFF && !outA.enable && !outB.enable;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved arrangement must shut outputs");

endmodule // dsi_lvds_output_config

// file: common/bridge_cfg_pkg.sv
// Function
// - channel A band counts 5 MHz steps; 0x08 is 40-45 MHz, codes below 0x08 or above 0x64 reserved
// - channel B clock band uses the same coding as A and resets to zero
// - top valid band codes are 0x63 (495-500 MHz) and 0x64 (500 MHz)
// - bit 7 set: data-enable low in active pixels; clear: high
// - bit 6 set (reset) drives hsync low during sync, clear drives it high
// - bit 5 set (reset) drives vsync low during sync, clear drives it high
// - link bit 0, receiver arrangement 00 or 01: one dual-link output
// - link bit 0, receiver arrangement 10: two independent single links
// - link bit 1 (reset) gives single link: channel A on, channel B off
// - channel A lane mode 0 gives 18 bpp, fourth lane off; 1 gives 24 bpp
// - channel B lane mode 0 gives 18 bpp, fourth lane off; 1 gives 24 bpp
// - channel A format 0 puts two MSBs per colour on lane four, 1 the LSBs
// - channel B format 0 puts two MSBs per colour on lane four, 1 the LSBs
// - format 1 with lane mode 0 drops the two LSBs per colour
// - arrangement 00 dual, 01 single (reset), 10 two singles, 11 reserved
package bridge_cfg_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_RX_ARRANGE = 8'h10;
  localparam logic [7:0] ADDR_BAND_A = 8'h12;
  localparam logic [7:0] ADDR_BAND_B = 8'h13;
  localparam logic [7:0] ADDR_OUT_CFG = 8'h18;
  localparam int ARRANGE_LSB = 5;

  // ----------------------------------------------------------------
  // reset values and code limits
  // ----------------------------------------------------------------
  localparam logic [7:0] BAND_RESET = 8'h00;
  localparam logic [7:0] OUT_CFG_RESET = 8'h70;
  localparam logic [7:0] BAND_FIRST = 8'h08;
  localparam logic [7:0] BAND_LAST = 8'h64;
  localparam logic [7:0] READ_IDLE = 8'h00;
  localparam logic [3:0] LANES_BASE = 4'h7;
  localparam logic [3:0] LANES_ALL = 4'hF;

  typedef enum logic [1:0] {
    RX_DUAL = 2'b00,
    RX_SINGLE = 2'b01,
    RX_TWO = 2'b10,
    RX_RSVD = 2'b11
  } rx_arrange_t;

  localparam rx_arrange_t ARRANGE_RESET = RX_SINGLE;

  typedef enum logic [1:0] {
    LINK_OFF = 2'b00,
    LINK_SINGLE = 2'b01,
    LINK_DUAL = 2'b10,
    LINK_TWO = 2'b11
  } link_mode_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  // bit order matches the output configuration register, bit 7 first
  typedef struct packed {
    logic dataEnableActiveLow;
    logic hsyncActiveLow;
    logic vsyncActiveLow;
    logic singleLink;
    logic chanAFourthLaneOn;
    logic chanBFourthLaneOn;
    logic chanALowBitsOnFourthLane;
    logic chanBLowBitsOnFourthLane;
  } out_cfg_t;

  typedef struct packed {
    rx_arrange_t rxArrange;
    logic [7:0] chanARxClockBand;
    logic [7:0] chanBRxClockBand;
    out_cfg_t outCfg;
  } cfg_t;

  localparam cfg_t CFG_RESET = '{
    rxArrange: ARRANGE_RESET,
    chanARxClockBand: BAND_RESET,
    chanBRxClockBand: BAND_RESET,
    outCfg: out_cfg_t'(OUT_CFG_RESET)
  };

  // one pixel of incoming video, syncs active high
  typedef struct packed {
    logic de;
    logic hs;
    logic vs;
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } pixel_t;

  // one flat-panel output channel
  typedef struct packed {
    logic enable;
    logic [3:0] laneOn;
    logic de;
    logic hs;
    logic vs;
    logic [17:0] baseData;
    logic [5:0] fourthLaneData;
  } lvds_chan_t;

endpackage

// file: verification/video_host_model.sv
`timescale 1ns/1ps
module video_host_model
  import bridge_cfg_pkg::*;
(
  // link clock
  input wire logic linkClk,
  // pattern chosen by the bench
  input wire pixel_t nextA,
  input wire pixel_t nextB,
  input wire logic full24,
  // video toward the bridge
  output pixel_t pixA,
  output pixel_t pixB
);

  // ------------------------------------------------------------
  // pixel shaping
  // ------------------------------------------------------------
  // 18 bpp video only carries six bits per colour, in the low bits
  function automatic pixel_t shape(input pixel_t p, input logic deep);
    pixel_t q;
    q = p;
    if (!deep)
    begin
      q.r[7:6] = 2'b00;
      q.g[7:6] = 2'b00;
      q.b[7:6] = 2'b00;
    end
    return q;
  endfunction

  // ------------------------------------------------------------
  // stream
  // ------------------------------------------------------------
  // new pixel launched just after each link edge; the bridge only
  // puts its link side into reset at the fourth link edge, after the first ones arrive
  always @(posedge linkClk)
  begin
    pixA <= shape(nextA, full24);
    pixB <= shape(nextB, full24);
  end

endmodule // video_host_model

// file: verification/dsi_lvds_output_config_tb_top.sv
`timescale 1ns/1ps
module dsi_lvds_output_config_tb_top
  import bridge_cfg_pkg::*;
;

  // ------------------------------------------------------------
  // signals and tables
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic [7:0] exp;
  } reg_row_t;
  typedef struct packed {
    logic [7:0] arrange;
    logic [7:0] cfg;
    logic full;
  } link_row_t;

  logic clk = 1'b0;
  logic linkClk, sys_rst, regWr, regRd, full24;
  logic chanABandOk, chanBBandOk;
  logic [7:0] regAddr, regWrData, regRdData, bandA, bandB;
  pixel_t pixA, pixB, nextA, nextB;
  lvds_chan_t outA, outB;
  link_mode_t linkMode;
  int miscompares, samplesChecked;

  reg_row_t regRows [11] = '{
    '{8'h12, 8'h07, 8'h07}, '{8'h12, 8'h08, 8'h08},
    '{8'h12, 8'h63, 8'h63}, '{8'h12, 8'h64, 8'h64},
    '{8'h12, 8'h65, 8'h65}, '{8'h13, 8'hFF, 8'hFF},
    '{8'h13, 8'h65, 8'h65},
    '{8'h13, 8'h09, 8'h09}, '{8'h10, 8'hFF, 8'h60},
    '{8'h18, 8'hA5, 8'hA5}, '{8'h11, 8'h3C, 8'h00}};
  // 18 bpp rows keep both format bits clear
  link_row_t linkRows [8] = '{
    '{8'h20, 8'h70, 1'b0}, '{8'h00, 8'h8C, 1'b1},
    '{8'h20, 8'h0E, 1'b1}, '{8'h40, 8'h47, 1'b1},
    '{8'h20, 8'h18, 1'b1}, '{8'h20, 8'h12, 1'b1},
    '{8'h60, 8'h00, 1'b0}, '{8'h00, 8'h10, 1'b0}};

  // system clock, and a link clock off in phase from it
  always #5 clk = ~clk;
  initial
  begin
    linkClk = 1'b0;
    #2.3;
    forever #15 linkClk = ~linkClk;
  end

  dsi_lvds_output_config i_dut (.clk(clk), .sys_rst(sys_rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .chanABandOk(chanABandOk),
    .chanBBandOk(chanBBandOk), .linkClk(linkClk), .pixA(pixA),
    .pixB(pixB), .outA(outA), .outB(outB), .linkMode(linkMode));

  video_host_model i_host (.linkClk(linkClk), .nextA(nextA),
    .nextB(nextB), .full24(full24), .pixA(pixA), .pixB(pixB));

  // ------------------------------------------------------------
  // expectations
  // ------------------------------------------------------------
  function automatic logic bandOk(input logic [7:0] code);
    return (code >= 8'h08) && (code <= 8'h64);
  endfunction

  function automatic link_mode_t expMode(input logic [1:0] arr,
                                         input logic single);
    if (single)
      return LINK_SINGLE;
    if (arr == 2'b00 || arr == 2'b01)
      return LINK_DUAL;
    if (arr == 2'b10)
      return LINK_TWO;
    return LINK_OFF;
  endfunction

  // a disabled channel stays all zero whatever the polarity
  function automatic lvds_chan_t expChan(input pixel_t p, input logic en,
      input logic four, input logic low, input logic [2:0] pol);
    lvds_chan_t c;
    c = '0;
    if (en)
    begin
      c.enable = 1'b1;
      c.laneOn = four ? 4'hF : 4'h7;
      c.de = p.de ^ pol[2];
      c.hs = p.hs ^ pol[1];
      c.vs = p.vs ^ pol[0];
      c.baseData = low ? {p.r[7:2], p.g[7:2], p.b[7:2]}
                       : {p.r[5:0], p.g[5:0], p.b[5:0]};
      if (four)
        c.fourthLaneData = low ? {p.r[1:0], p.g[1:0], p.b[1:0]}
                               : {p.r[7:6], p.g[7:6], p.b[7:6]};
    end
    return c;
  endfunction

  // ------------------------------------------------------------
  // compare tasks and verdict
  // ------------------------------------------------------------
  task automatic cmpByte(input logic [7:0] got, input logic [7:0] exp);
    samplesChecked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t byte %h want %h", $time, got, exp);
    end
  endtask

  task automatic cmpBit(input logic got, input logic exp);
    samplesChecked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t flag %b want %b", $time, got, exp);
    end
  endtask

  task automatic cmpMode(input link_mode_t got, input link_mode_t exp);
    samplesChecked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t mode %b want %b", $time, got, exp);
    end
  endtask

  task automatic cmpChan(input lvds_chan_t got, input lvds_chan_t exp);
    samplesChecked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t chan %h want %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("compares %0d mismatches %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // bus and link tasks
  // ------------------------------------------------------------
  // one bus cycle; every signal set once, right after an edge
  task automatic drive(input logic wr, input logic rd,
                       input logic [7:0] a, input logic [7:0] d);
    regWr <= wr;
    regRd <= rd;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
  endtask

  task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
    drive(1'b1, 1'b0, a, d);
    drive(1'b0, 1'b0, a, d);
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rdCheck(input logic [7:0] a, input logic [7:0] exp);
    drive(1'b0, 1'b1, a, 8'h00);
    regRd <= 1'b0;
    @(negedge clk);
    cmpByte(regRdData, exp);
    @(posedge clk);
    @(negedge clk);
    cmpByte(regRdData, 8'h00);
    @(posedge clk);
  endtask

  // a config change needs some ten link periods to reach the link
  task automatic linkCheck(input logic [7:0] arr, input logic [7:0] c);
    link_mode_t m;
    lvds_chan_t ea;
    lvds_chan_t eb;
    m = expMode(arr[6:5], c[4]);
    repeat (20) @(posedge linkClk);
    @(negedge clk);
    // video is settled by now, so the expectation uses the new shape
    ea = expChan(pixA, m != LINK_OFF, c[3], c[1], c[7:5]);
    eb = expChan(pixB, m == LINK_DUAL || m == LINK_TWO, c[2], c[0],
                 c[7:5]);
    cmpMode(linkMode, m);
    cmpChan(outA, ea);
    cmpChan(outB, eb);
    @(posedge clk);
  endtask

  task automatic doReset();
    sys_rst <= 1'b1;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
  endtask

  task automatic resetChecks();
    rdCheck(ADDR_BAND_A, 8'h00);
    rdCheck(ADDR_BAND_B, 8'h00);
    rdCheck(ADDR_OUT_CFG, 8'h70);
    rdCheck(ADDR_RX_ARRANGE, 8'h20);
    cmpBit(chanABandOk, 1'b0);
    cmpBit(chanBBandOk, 1'b0);
    linkCheck(8'h20, 8'h70);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    sys_rst = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    full24 = 1'b0;
    nextA = {1'b1, 1'b0, 1'b1, 8'hC5, 8'h3A, 8'h96};
    nextB = {1'b0, 1'b1, 1'b0, 8'h5C, 8'hE3, 8'h69};
    miscompares = 0;
    samplesChecked = 0;
    bandA = 8'h00;
    bandB = 8'h00;
    doReset();
    resetChecks();
    $display("test reset done");
    foreach (regRows[i])
    begin
      wrReg(regRows[i].addr, regRows[i].data);
      if (regRows[i].addr == ADDR_BAND_A)
        bandA = regRows[i].data;
      if (regRows[i].addr == ADDR_BAND_B)
        bandB = regRows[i].data;
      rdCheck(regRows[i].addr, regRows[i].exp);
      cmpBit(chanABandOk, bandOk(bandA));
      cmpBit(chanBBandOk, bandOk(bandB));
    end
    // later writes must not disturb the band fields
    rdCheck(ADDR_BAND_A, 8'h65);
    rdCheck(ADDR_BAND_B, 8'h09);
    $display("test registers done");
    foreach (linkRows[i])
    begin
      full24 <= linkRows[i].full;
      wrReg(ADDR_RX_ARRANGE, linkRows[i].arrange);
      wrReg(ADDR_OUT_CFG, linkRows[i].cfg);
      linkCheck(linkRows[i].arrange, linkRows[i].cfg);
    end
    $display("test link modes done");
    // write straight into a read with no idle cycle
    drive(1'b1, 1'b0, ADDR_OUT_CFG, 8'h5B);
    rdCheck(ADDR_OUT_CFG, 8'h5B);
    cmpBit(chanABandOk, 1'b0);
    $display("test back to back done");
    wrReg(ADDR_BAND_A, 8'h40);
    doReset();
    resetChecks();
    $display("test second reset done");
    results();
  end

  // hang guard, well beyond the expected run time
  initial
  begin
    #200000;
    miscompares++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    results();
  end

endmodule // dsi_lvds_output_config_tb_top
